/* File: verification/dit_regs_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Checker
// ----------------------------------------
module dit_regs_monitor (
  input wire logic        clock, srst, clk_en, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        test_mode, error_irq_out, terminal_count_irq_out,
  input wire logic        func_error_irq, func_terminal_count_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire logic rd = psel && !penable && !pwrite && clk_en;
  wire logic wr = psel && penable && pwrite && clk_en;
  a_cfg_word: assert property (rd && paddr == 12'hFEC
    |=> prdata == 32'h0000000A) else $error("bad config word");
  a_rev_word: assert property (rd && paddr == 12'hFE8 |=> prdata ==
    {24'h0, dit_pkg::REVISION_NUMBER, dit_pkg::MAKER_CODE_HIGH})
    else $error("bad revision word");
  a_cell_low: assert property (rd && paddr == 12'hFF0 |=> prdata ==
    {24'h0, dit_pkg::CELL_IDENT_VALUE[7:0]}) else $error("bad cell byte 0");
  a_cell_top: assert property (rd && paddr == 12'hFFC |=> prdata ==
    {24'h0, dit_pkg::CELL_IDENT_VALUE[31:24]}) else $error("bad cell byte 3");
  a_ctrl_clear: assert property (disable iff (1'b0) srst && clk_en
    |=> !test_mode) else $error("test mode kept over reset");
  a_mode_write: assert property (wr && paddr == 12'h500
    |=> test_mode == $past(pwdata[0])) else $error("test mode not written");
  a_irq_follow: assert property (!test_mode |->
    {error_irq_out, terminal_count_irq_out} ==
    {func_error_irq, func_terminal_count_irq}) else $error("irq not passed");
  a_irq_force: assert property (wr && test_mode && paddr == 12'h50C
    |=> {error_irq_out, terminal_count_irq_out} == $past(pwdata[1:0]))
    else $error("irq not forced");
  c_mode_on: cover property (wr && paddr == 12'h500 && pwdata[0]);
  c_irq_set: cover property (wr && test_mode && paddr == 12'h50C);
  c_cfg_read: cover property (rd && paddr == 12'hFEC);
endmodule : dit_regs_monitor
bind dit_regs dit_regs_monitor u_mon (.clock(clock), .srst(srst),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .test_mode(test_mode),
  .error_irq_out(error_irq_out), .func_error_irq(func_error_irq),
  .terminal_count_irq_out(terminal_count_irq_out),
  .func_terminal_count_irq(func_terminal_count_irq));
`default_nettype wire

/* File: verification/dit_regs_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Bench
// ----------------------------------------
module dit_regs_tb_top;
  logic        clock, srst, clk_en, psel, penable, pwrite, fe, ft;
  logic        pready, pslverr, eo, to, tmo, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] tm;
  logic [1:0]  it;
  int          error_cnt, num_checks, cyc, seed, k;
  logic [11:0] ads [8] = '{12'h500, 12'hFE8, 12'hFEC, 12'hFF0,
                           12'hFF4, 12'hFF8, 12'hFFC, 12'h004};
  dit_regs DUT (.clock(clock), .srst(srst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .func_error_irq(fe), .func_terminal_count_irq(ft), .error_irq_out(eo),
    .terminal_count_irq_out(to), .test_mode(tmo));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Unknown addresses read as zero, so the model default is zero too.
  function automatic logic [31:0] mdl(input logic [11:0] a);
    case (a)
      12'h500: return {16'h0, tm};
      12'h50C: return {30'h0, tm[0] ? it : {fe, ft}};
      12'hFE8: return {24'h0, dit_pkg::REVISION_NUMBER,
                       dit_pkg::MAKER_CODE_HIGH};
      12'hFEC: return {24'h0, 1'b0, 3'h0, 1'b1, 3'h2};
      12'hFF0, 12'hFF4, 12'hFF8, 12'hFFC:
        return {24'h0, dit_pkg::CELL_IDENT_VALUE[8*a[3:2] +: 8]};
      default: return 32'h0;
    endcase
  endfunction : mdl
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (clk_en && w && a == 12'h500) tm = d[15:0];
    if (clk_en && w && a == 12'h50C) it = d[1:0];
  endtask : apb
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    seed = 31687; srst = 1'b1; clk_en = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0; fe = 1'b0; ft = 1'b0;
    tm = 16'h0; it = 2'h0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    foreach (ads[i]) begin
      apb(1'b1, ads[i], ads[i] == 12'h500 ? 32'h0 : $random(seed));
      apb(1'b0, ads[i], 32'h0);
      chk(r, mdl(ads[i]));
      chk({31'h0, se}, {31'h0, ads[i] == 12'h004});
    end
    $display("ident test done");
    for (k = 0; k < 8; k++) begin
      {fe, ft} <= 2'($random(seed));
      apb(1'b1, 12'h500, {31'h0, k[2]});
      if (k[2]) apb(1'b1, 12'h50C, {30'h0, k[1:0]});
      apb(1'b0, 12'h50C, 32'h0);
      chk(r, mdl(12'h50C));
      chk({31'h0, tmo}, {31'h0, k[2]});
      chk({30'h0, eo, to}, mdl(12'h50C));
    end
    $display("test mode test done");
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    tm = 16'h0;
    it = 2'h0;
    apb(1'b0, 12'h500, 32'h0);
    chk(r, mdl(12'h500));
    chk({31'h0, tmo}, 32'h0);
    $display("reset test done");
    clk_en <= 1'b0;
    apb(1'b1, 12'h500, 32'h1);
    clk_en <= 1'b1;
    apb(1'b0, 12'h500, 32'h0);
    chk(r, mdl(12'h500));
    chk({31'h0, tmo}, 32'h0);
    $display("clock enable test done");
    end_sim();
  end
endmodule : dit_regs_tb_top
`default_nettype wire

/* File: verilog/dit_pkg.sv */
package dit_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_TEST_MODE_CONTROL = 12'h500;
  localparam logic [11:0] OFS_IRQ_TEST_OUTPUT   = 12'h50C;
  localparam logic [11:0] OFS_PERIPH_IDENT_WORD2 = 12'hFE8;
  localparam logic [11:0] OFS_PERIPH_CONFIG_WORD = 12'hFEC;
  localparam logic [11:0] OFS_CELL_IDENT_BYTE0  = 12'hFF0;
  localparam logic [11:0] OFS_CELL_IDENT_BYTE1  = 12'hFF4;
  localparam logic [11:0] OFS_CELL_IDENT_BYTE2  = 12'hFF8;
  localparam logic [11:0] OFS_CELL_IDENT_BYTE3  = 12'hFFC;

  // ---------------------------------------------------------------
  // Identification values
  // ---------------------------------------------------------------
  // Arbitrary neutral values; not any real maker's codes.
  localparam logic [3:0]  REVISION_NUMBER  = 4'h0;
  localparam logic [3:0]  MAKER_CODE_HIGH  = 4'h0;
  localparam logic [31:0] CELL_IDENT_VALUE = 32'h00000000;

  // ---------------------------------------------------------------
  // Configuration byte fields
  // ---------------------------------------------------------------
  localparam logic       CFG_REQUESTORS_16  = 1'b0;
  localparam logic [2:0] CFG_BUS_WIDTH_32   = 3'h0;
  localparam logic       CFG_TWO_MASTERS    = 1'b1;
  localparam logic [2:0] CFG_CHANNEL_FIELD  = 3'h2;

  // ---------------------------------------------------------------
  // Test register layout
  // ---------------------------------------------------------------
  localparam int          TEST_CTRL_WIDTH  = 16;
  localparam int          TEST_ENABLE_BIT  = 0;
  localparam int          IRQ_TC_BIT       = 0;
  localparam int          IRQ_ERR_BIT      = 1;
  localparam logic [15:0] TEST_CTRL_RESET  = 16'h0000;
  localparam logic [1:0]  IRQ_TEST_RESET   = 2'h0;

  typedef struct packed {
    logic [15:0] test_mode_control_q;
    logic [1:0]  irq_test_output_q;
    logic [31:0] prdata_q;
  } dit_state_type;

  typedef struct packed {
    logic        error_irq;
    logic        terminal_count_irq;
  } dit_irq_type;

endpackage : dit_pkg

/* File: verilog/dit_regs.sv */
// ---------------------------------------------------------------
// Overview of operation
// ---------------------------------------------------------------
// Overview of operation
// - Cell ident words 0xFF0-0xFFC each give one byte of a 32-bit value.
// - Word 0xFE8 gives the revision in bits 7:4 and maker code in 3:0.
// - Word 0xFEC gives the build configuration in its low byte.
// - Configuration bit 7 reads zero, meaning 16 requestors.
// - Configuration bits 6:4 read 000, meaning a 32-bit master bus.
// - Configuration bit 3 reads one, meaning two bus masters.
// - Configuration bits 2:0 always read 010.
// - The cell ident value is fixed, ignores writes and needs no reset.
// - The 16-bit read/write test control at 0x500 clears on reset.
// - Test control bit 0 puts test registers in place of functional logic.
// - In test mode word 0x50C drives and reads back the irq outputs.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`default_nettype none

module dit_regs (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        func_error_irq,
  input  wire logic        func_terminal_count_irq,
  output logic             error_irq_out,
  output logic             terminal_count_irq_out,
  output logic             test_mode
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      dit_pkg::OFS_TEST_MODE_CONTROL,
      dit_pkg::OFS_IRQ_TEST_OUTPUT,
      dit_pkg::OFS_PERIPH_IDENT_WORD2,
      dit_pkg::OFS_PERIPH_CONFIG_WORD,
      dit_pkg::OFS_CELL_IDENT_BYTE0,
      dit_pkg::OFS_CELL_IDENT_BYTE1,
      dit_pkg::OFS_CELL_IDENT_BYTE2,
      dit_pkg::OFS_CELL_IDENT_BYTE3: is_mapped = 1'b1;
      default:                       is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dit_pkg::dit_state_type state_q;
  dit_pkg::dit_state_type state_d;
  dit_pkg::dit_irq_type   irq_mux;
  logic                   access;
  logic [7:0]             config_byte;
  logic [31:0]            cell_word;
  logic [31:0]            rd_value;

  assign access  = psel && penable;
  assign pready  = 1'b1;
  assign pslverr = access && !is_mapped(paddr);

  assign test_mode = state_q.test_mode_control_q[dit_pkg::TEST_ENABLE_BIT];

  // Functional sources pass through unless test mode overrides them.
  always_comb begin
    if (test_mode) begin
      irq_mux.error_irq          = state_q.irq_test_output_q[dit_pkg::IRQ_ERR_BIT];
      irq_mux.terminal_count_irq = state_q.irq_test_output_q[dit_pkg::IRQ_TC_BIT];
    end else begin
      irq_mux.error_irq          = func_error_irq;
      irq_mux.terminal_count_irq = func_terminal_count_irq;
    end
  end

  assign error_irq_out          = irq_mux.error_irq;
  assign terminal_count_irq_out = irq_mux.terminal_count_irq;

  // Channel field 010 denotes eight channels.
  assign config_byte = {dit_pkg::CFG_REQUESTORS_16,
                        dit_pkg::CFG_BUS_WIDTH_32,
                        dit_pkg::CFG_TWO_MASTERS,
                        dit_pkg::CFG_CHANNEL_FIELD};

  // Constant, so no reset and no write path can disturb it.
  assign cell_word = dit_pkg::CELL_IDENT_VALUE;

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Undefined upper bits read as zero.
  always_comb begin
    rd_value = 32'h00000000;
    case (paddr)
      dit_pkg::OFS_TEST_MODE_CONTROL:
        rd_value = {16'h0000, state_q.test_mode_control_q};
      dit_pkg::OFS_IRQ_TEST_OUTPUT:
        rd_value = {30'h00000000, irq_mux.error_irq,
                    irq_mux.terminal_count_irq};
      dit_pkg::OFS_PERIPH_IDENT_WORD2:
        rd_value = {24'h000000, dit_pkg::REVISION_NUMBER,
                    dit_pkg::MAKER_CODE_HIGH};
      dit_pkg::OFS_PERIPH_CONFIG_WORD:
        rd_value = {24'h000000, config_byte};
      dit_pkg::OFS_CELL_IDENT_BYTE0:
        rd_value = {24'h000000, cell_word[7:0]};
      dit_pkg::OFS_CELL_IDENT_BYTE1:
        rd_value = {24'h000000, cell_word[15:8]};
      dit_pkg::OFS_CELL_IDENT_BYTE2:
        rd_value = {24'h000000, cell_word[23:16]};
      dit_pkg::OFS_CELL_IDENT_BYTE3:
        rd_value = {24'h000000, cell_word[31:24]};
      default:
        rd_value = 32'h00000000;
    endcase
  end

  // Read data is registered in the setup cycle so it is stable in access.
  always_comb begin
    state_d = state_q;
    if (psel && !penable && !pwrite) begin
      state_d.prdata_q = rd_value;
    end
    if (access && pwrite) begin
      case (paddr)
        dit_pkg::OFS_TEST_MODE_CONTROL:
          // Only bit 0 has meaning; software keeps the rest zero.
          state_d.test_mode_control_q = pwdata[15:0];
        dit_pkg::OFS_IRQ_TEST_OUTPUT:
          state_d.irq_test_output_q = pwdata[1:0];
        default:
          state_d = state_d;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q.test_mode_control_q <= dit_pkg::TEST_CTRL_RESET;
      state_q.irq_test_output_q   <= dit_pkg::IRQ_TEST_RESET;
      state_q.prdata_q            <= 32'h00000000;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.prdata_q;

endmodule : dit_regs

`default_nettype wire
